// *** hdl/smsp_pkg.sv ***
// Purpose: shared constants and carrier types of the serial master/slave port
// Assumes: one 25 MHz system clock, synchronous active-low reset
// Notes:   every reset value and count used by more than one file lives here
//==============================================================
// package
//==============================================================
package smsp_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int BYTE_BITS = 8;
    localparam int RX_FIFO_DEPTH = 16;

    // serial clock half period at the fastest rate, in cpu cycles (fcpu/4)
    localparam int HALF_MIN = 2;
    // number of selectable master rates; higher codes clamp to the slowest
    localparam logic [2:0] RATE_COUNT = 3'h6;
    localparam logic [2:0] RATE_SLOWEST = 3'h5;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // synchroniser resting values: sck, mosi, miso, select (select idles high)
    localparam logic [3:0] SYNC_RESET = 4'h8;
    localparam int SYNC_SCK = 0;
    localparam int SYNC_MOSI = 1;
    localparam int SYNC_MISO = 2;
    localparam int SYNC_SEL = 3;

    typedef struct packed {
        logic portIrqEnable;
        logic portEnable;
        logic [2:0] clockRateSel;
        logic masterSelect;
        logic cpol;
        logic cpha;
    } smsp_ctrl_t;

    typedef struct packed {
        logic swSelectManage;
        logic swSelectLevel;
    } smsp_sel_t;

    typedef struct packed {
        logic transferDoneFlag;
        logic writeCollisionFlag;
        logic overrunFlag;
        logic masterFaultFlag;
    } smsp_status_t;

    localparam smsp_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0};
    localparam smsp_sel_t SEL_RESET = '{1'b0, 1'b0};
    localparam smsp_status_t STATUS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};
    localparam logic [7:0] DATA_RESET = 8'h00;

endpackage

// *** hdl/smsp_fifo.sv ***
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset, DEPTH a power of two
// Notes:   inReady falls when full, outValid falls when empty
`timescale 1ns/1ps
`default_nettype none
module smsp_fifo
    import smsp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            wrPtr <= push ? wrPtr + AW'(1) : wrPtr;
            rdPtr <= pop ? rdPtr + AW'(1) : rdPtr;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // smsp_fifo
`default_nettype wire

// *** hdl/smsp_port.sv ***
// Purpose: serial master/slave port, 8-bit full duplex, msb first
// Assumes: register accesses arrive as one-cycle strobes from the cpu side
// Notes:   pin inputs pass a three-stage filter, which bounds usable sck rates
//==============================================================
// Summary of operation
// - bytes shift msb first, master out to slave in, slave out to master in
// - only the master starts; the slave shifts its byte back on the same clock
// - both ends must share polarity and phase, one of four timings
// - phase 1 captures on the second edge, phase 0 on the first edge
// - software select management takes select level from the level bit
// - slave with phase 0 writing while still selected is a write collision
// - master clock picks one of six rates, fastest a quarter of cpu clock
// - slave accepts up to a quarter of cpu clock (pin filter); back-to-back not sustainable
// - serial clock idles at the polarity level
// - in master mode, master select and port enable drop whenever select level is low
// - master data write loads shift register and starts shifting out once the receive fifo has room
// - each finished transfer sets done flag; interrupt if enabled and unmasked
// - master done flag clears by status access then data read
// - data writes are ignored while done flag set until status read
// - slave data write preloads shift register; master clock drives shifting
// - slave done flag clears by status access then data read or write
// - master fault sets fault flag, may interrupt, drops enable and master
// - data write during a transfer is dropped and flags a collision
// - byte finishing with done flag set flags overrun, keeps older byte
`timescale 1ns/1ps
`default_nettype none
module smsp_port
    import smsp_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ctrlWrite,
    input wire smsp_ctrl_t ctrlIn,
    input wire logic csrWrite,
    input wire smsp_sel_t selIn,
    input wire logic csrRead,
    input wire logic dataWrite,
    input wire logic [7:0] dataIn,
    input wire logic dataRead,
    input wire logic cpuIntMask,
    output smsp_ctrl_t ctrlOut,
    output smsp_sel_t selOut,
    output smsp_status_t statusOut,
    output logic [7:0] rxData,
    output logic irq,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic ssN,
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] rxStream
);
    typedef enum logic [1:0] {M_IDLE, M_HOLD, M_SHIFT} smsp_mstate_t;

    //==============================================================
    // pin filters
    //==============================================================
    wire [3:0] pinRaw = {ssN, misoIn, mosiIn, sckIn};
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncC;
    logic [3:0] pinStable;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gSync
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    syncA[g] <= SYNC_RESET[g];
                    syncB[g] <= SYNC_RESET[g];
                    syncC[g] <= SYNC_RESET[g];
                    pinStable[g] <= SYNC_RESET[g];
                end
                else
                begin
                    syncA[g] <= pinRaw[g];
                    syncB[g] <= syncA[g];
                    syncC[g] <= syncB[g];
                    // a change counts only once two stages agree
                    pinStable[g] <= (syncB[g] == syncC[g]) ? syncB[g] : pinStable[g];
                end
            end
        end
    endgenerate

    //==============================================================
    // state
    //==============================================================
    smsp_ctrl_t ctrl;
    smsp_sel_t sel;
    smsp_status_t st;
    smsp_mstate_t mstate;
    logic [7:0] shreg;
    logic outBit;
    logic [6:0] halfCnt;
    logic [3:0] edgeCnt;
    logic [2:0] bitCnt;
    logic sckPrev;
    logic sckReg;
    logic spifArmed;
    logic spifReadSeen;
    logic wcolArmed;
    logic modfArmed;

    function automatic logic [6:0] halfLoad(input logic [2:0] rate);
        logic [2:0] r;
        r = (rate < RATE_COUNT) ? rate : RATE_SLOWEST;
        return 7'((HALF_MIN << r) - 1);
    endfunction

    //==============================================================
    // select, mode and tick decoding
    //==============================================================
    wire ssInternal = sel.swSelectManage ? sel.swSelectLevel : pinStable[SYNC_SEL];
    wire ssLow = !ssInternal;
    wire masterMode = ctrl.portEnable && ctrl.masterSelect;
    wire slaveMode = ctrl.portEnable && !ctrl.masterSelect;
    wire faultNow = masterMode && ssLow;

    wire sckS = pinStable[SYNC_SCK];
    wire masterTick = (mstate == M_SHIFT) && (halfCnt == 7'h00);
    wire masterLead = !edgeCnt[0];
    wire slaveTick = slaveMode && ssLow && (sckS != sckPrev);
    wire slaveLead = (sckS != ctrl.cpol);
    wire tick = masterTick || slaveTick;
    wire lead = masterTick ? masterLead : slaveLead;
    wire capture = tick && (lead ^ ctrl.cpha);
    wire drive = tick && !capture;
    wire inBit = masterMode ? pinStable[SYNC_MISO] : pinStable[SYNC_MOSI];
    wire [7:0] rxByte = capture ? {shreg[6:0], inBit} : shreg;

    wire masterDone = masterTick && (edgeCnt == LAST_EDGE);
    wire slaveDone = slaveTick && capture && (bitCnt == LAST_BIT);
    wire done = masterDone || slaveDone;

    // in phase 0 a still-selected slave counts as mid-transfer
    wire slaveBusy = slaveMode && ssLow && (!ctrl.cpha || bitCnt != 3'h0);
    wire busy = (mstate != M_IDLE) || slaveBusy;
    wire writeBlocked = st.transferDoneFlag && !spifReadSeen;
    wire writeTaken = dataWrite && !busy && !writeBlocked;
    wire collision = dataWrite && busy && !writeBlocked;

    wire csrAccess = csrRead || csrWrite;
    wire spifClr = spifArmed && (dataRead || (!ctrl.masterSelect && dataWrite));
    wire keepOld = st.transferDoneFlag && !spifClr;
    wire wcolClr = wcolArmed && (dataRead || dataWrite);
    wire modfClr = modfArmed && ctrlWrite;

    wire fifoInReady;
    wire startShift = (mstate == M_HOLD) && fifoInReady;

    //==============================================================
    // flag next values (set wins over clear)
    //==============================================================
    smsp_status_t next_st;
    assign next_st.transferDoneFlag = done || (st.transferDoneFlag && !spifClr);
    assign next_st.overrunFlag = (done && keepOld) || (st.overrunFlag && !csrRead);
    assign next_st.writeCollisionFlag = collision || (st.writeCollisionFlag && !wcolClr);
    assign next_st.masterFaultFlag = faultNow || (st.masterFaultFlag && !modfClr);

    // enable and master bits may only be set outside a pending fault
    wire ctrlAllowed = !st.masterFaultFlag || modfArmed;
    smsp_ctrl_t wrCtrl;
    assign wrCtrl.portIrqEnable = ctrlIn.portIrqEnable;
    assign wrCtrl.portEnable = ctrlIn.portEnable && ctrlAllowed;
    assign wrCtrl.clockRateSel = ctrlIn.clockRateSel;
    assign wrCtrl.masterSelect = ctrlIn.masterSelect && ctrlAllowed;
    assign wrCtrl.cpol = ctrlIn.cpol;
    assign wrCtrl.cpha = ctrlIn.cpha;
    smsp_ctrl_t next_ctrl;
    assign next_ctrl.portIrqEnable = ctrlWrite ? wrCtrl.portIrqEnable : ctrl.portIrqEnable;
    assign next_ctrl.portEnable = !faultNow && (ctrlWrite ? wrCtrl.portEnable : ctrl.portEnable);
    assign next_ctrl.clockRateSel = ctrlWrite ? wrCtrl.clockRateSel : ctrl.clockRateSel;
    assign next_ctrl.masterSelect = !faultNow && (ctrlWrite ? wrCtrl.masterSelect : ctrl.masterSelect);
    assign next_ctrl.cpol = ctrlWrite ? wrCtrl.cpol : ctrl.cpol;
    assign next_ctrl.cpha = ctrlWrite ? wrCtrl.cpha : ctrl.cpha;

    //==============================================================
    // control and status registers
    //==============================================================
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl <= CTRL_RESET;
            sel <= SEL_RESET;
            st <= STATUS_RESET;
            rxData <= DATA_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
            sel <= csrWrite ? selIn : sel;
            st <= next_st;
            rxData <= (done && !keepOld) ? rxByte : rxData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            spifArmed <= 1'b0;
            spifReadSeen <= 1'b0;
            wcolArmed <= 1'b0;
            modfArmed <= 1'b0;
        end
        else
        begin
            spifArmed <= !done && next_st.transferDoneFlag && (spifArmed || csrAccess);
            spifReadSeen <= !done && next_st.transferDoneFlag && (spifReadSeen || csrRead);
            wcolArmed <= !collision && next_st.writeCollisionFlag && (wcolArmed || csrRead);
            modfArmed <= !faultNow && next_st.masterFaultFlag && (modfArmed || csrRead);
        end
    end

    //==============================================================
    // master sequencer
    //==============================================================
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mstate <= M_IDLE;
            halfCnt <= 7'h00;
            edgeCnt <= 4'h0;
            sckReg <= 1'b0;
        end
        else if (!masterMode)
        begin
            mstate <= M_IDLE;
            sckReg <= ctrl.cpol;
        end
        else
        begin
            case (mstate)
                M_IDLE:
                begin
                    sckReg <= ctrl.cpol;
                    edgeCnt <= 4'h0;
                    mstate <= writeTaken ? M_HOLD : M_IDLE;
                end
                M_HOLD:
                begin
                    // a full receive fifo stalls the next byte here
                    halfCnt <= halfLoad(ctrl.clockRateSel);
                    mstate <= startShift ? M_SHIFT : M_HOLD;
                end
                M_SHIFT:
                begin
                    halfCnt <= masterTick ? halfLoad(ctrl.clockRateSel) : halfCnt - 7'h01;
                    sckReg <= masterTick ? !sckReg : sckReg;
                    edgeCnt <= masterTick ? edgeCnt + 4'h1 : edgeCnt;
                    mstate <= masterDone ? M_IDLE : M_SHIFT;
                end
                default:
                begin
                    mstate <= M_IDLE;
                end
            endcase
        end
    end

    //==============================================================
    // shared shifter
    //==============================================================
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            shreg <= DATA_RESET;
            outBit <= 1'b0;
            bitCnt <= 3'h0;
            sckPrev <= SYNC_RESET[SYNC_SCK];
        end
        else
        begin
            sckPrev <= sckS;
            shreg <= writeTaken ? dataIn : rxByte;
            outBit <= writeTaken ? dataIn[7] : (drive ? shreg[7] : outBit);
            if (!slaveMode || !ssLow || slaveDone)
            begin
                bitCnt <= 3'h0;
            end
            else
            begin
                bitCnt <= (slaveTick && capture) ? bitCnt + 3'h1 : bitCnt;
            end
        end
    end

    //==============================================================
    // receive fifo and outputs
    //==============================================================
    smsp_fifo #(
        .WIDTH(BYTE_BITS),
        .DEPTH(FIFO_DEPTH)
    ) uRxFifo (
        .clk(clk),
        .nrst(nrst),
        .inValid(done),
        .inReady(fifoInReady),
        .inData(rxByte),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxStream)
    );

    assign ctrlOut = ctrl;
    assign selOut = sel;
    assign statusOut = st;
    assign irq = ctrl.portIrqEnable && !cpuIntMask
        && (st.transferDoneFlag || st.overrunFlag || st.masterFaultFlag);
    assign sckOut = sckReg;
    assign sckOe = masterMode;
    assign mosiOut = outBit;
    assign mosiOe = masterMode;
    assign misoOut = outBit;
    assign misoOe = slaveMode && ssLow;

    //==============================================================
    // checks
    //==============================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sFault;
        masterMode && ssLow;
    endsequence
    // helper: age of a shift begun at the fastest rate with the setup left alone
    logic [4:0] shiftAge;
    logic fastClean;
    always_ff @(posedge clk)
    begin
        shiftAge <= (nrst && mstate == M_SHIFT) ? shiftAge + 5'h01 : 5'h00;
        fastClean <= nrst && !ctrlWrite && (startShift ? ctrl.clockRateSel == 3'h0
            : fastClean && masterMode);
    end

    a_fault_drops_enable: assert property (sFault |=> !ctrl.portEnable && !ctrl.masterSelect
        && st.masterFaultFlag)
        else $error("fault did not drop enable and master");
    a_done_sets_flag: assert property (done |=> st.transferDoneFlag)
        else $error("done flag not set after transfer");
    a_overrun_keeps_byte: assert property (done && keepOld |=> st.overrunFlag
        && $stable(rxData))
        else $error("overrun did not keep older byte");
    a_write_collision: assert property (dataWrite && busy && !writeBlocked
        |=> st.writeCollisionFlag && (mstate != M_HOLD || $past(mstate) == M_HOLD))
        else $error("collision write not flagged or not dropped");
    a_master_clear_seq: assert property (spifArmed && dataRead && !done
        |=> !st.transferDoneFlag)
        else $error("done flag survived clearing sequence");
    a_blocked_write: assert property (masterMode && mstate == M_IDLE && writeBlocked
        && dataWrite |=> mstate == M_IDLE)
        else $error("write accepted while done flag pending");
    a_idle_clock_level: assert property (mstate == M_IDLE && masterMode |=> sckOut == ctrl.cpol
        || !masterMode)
        else $error("serial clock not at idle level");
    a_irq_on_done: assert property (done && ctrl.portIrqEnable && !cpuIntMask
        && !ctrlWrite |=> irq)
        else $error("no interrupt after transfer");
    a_byte_duration: assert property (fastClean && (masterDone || shiftAge == 5'h1F)
        |-> masterDone && shiftAge == 5'h1F)
        else $error("fastest rate byte not 32 cycles");
    a_slave_no_drive: assert property (slaveMode && ssInternal |-> !misoOe && !sckOe)
        else $error("deselected slave drives a line");

endmodule // smsp_port
`default_nettype wire

// *** tb/smsp_slave_model.sv ***
// Purpose: behavioural serial slave device facing the port in master mode
// Assumes: select comes from the bench; polarity and phase match the port
// Notes:   a released output shows the inverse of its last bit, never a held value
`timescale 1ns/1ps
`default_nettype none
//==============================================================
// slave device
//==============================================================
module smsp_slave_model
(
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    logic [7:0] shiftReg;
    initial miso = 1'b0;
    always @(negedge selN)
    begin
        shiftReg = txByte;
        if (!cpha)
            miso = shiftReg[7];
    end
    always @(posedge selN)
        miso = ~miso;
    always @(sck)
    begin
        if (!selN && ((sck !== cpol) == !cpha))
            rxByte = {rxByte[6:0], mosi};
        else if (!selN && cpha)
        begin
            miso = shiftReg[7];
            shiftReg = shiftReg << 1;
        end
        else if (!selN)
        begin
            shiftReg = shiftReg << 1;
            miso = shiftReg[7];
        end
    end
endmodule // smsp_slave_model
`default_nettype wire

// *** tb/tb_smsp_port.sv ***
// Purpose: self-checking bench of the serial port in master and slave mode
// Assumes: select handled in software except in the pin fault and slave mode cases
// Notes:   received bytes are only compared at the slower rates (pin filter lag)
`timescale 1ns/1ps
`default_nettype none
module tb_smsp_port;
    import smsp_pkg::*;
    logic clk, nrst, ctrlWrite, csrWrite, csrRead, dataWrite, dataRead, cpuIntMask;
    smsp_ctrl_t ctrlIn, ctrlOut;
    smsp_sel_t selIn, selOut;
    smsp_status_t statusOut;
    logic [7:0] dataIn, rxData, rxStream, txByte, slvRx;
    logic irq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, ssN, rxValid, rxReady;
    logic slvSelN, slvMiso, tbSck, tbMosi;
    int mismatches, n_compared, i, k, n, t, half, last;
    logic prev;
    logic [8:0] expq [0:16];
    smsp_port dut_u (.clk(clk), .nrst(nrst), .ctrlWrite(ctrlWrite), .ctrlIn(ctrlIn),
        .csrWrite(csrWrite), .selIn(selIn), .csrRead(csrRead), .dataWrite(dataWrite),
        .dataIn(dataIn), .dataRead(dataRead), .cpuIntMask(cpuIntMask), .ctrlOut(ctrlOut),
        .selOut(selOut), .statusOut(statusOut), .rxData(rxData), .irq(irq),
        .sckIn(sckOe ? sckOut : tbSck), .sckOut(sckOut), .sckOe(sckOe),
        .mosiIn(mosiOe ? mosiOut : tbMosi), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoIn(misoOe ? misoOut : slvMiso),
        .misoOut(misoOut), .misoOe(misoOe), .ssN(ssN), .rxValid(rxValid),
        .rxReady(rxReady), .rxStream(rxStream));
    smsp_slave_model slv_u (.sck(sckOut), .mosi(mosiOut), .selN(slvSelN),
        .cpol(ctrlOut.cpol), .cpha(ctrlOut.cpha), .txByte(txByte), .miso(slvMiso),
        .rxByte(slvRx));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    //==============================================================
    // access tasks
    //==============================================================
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task acc(input int kind, input logic [7:0] v);
        @(posedge clk);
        case (kind)
            0: begin ctrlWrite <= 1'b1; ctrlIn <= smsp_ctrl_t'(v); end
            1: begin csrWrite <= 1'b1; selIn <= smsp_sel_t'(v[1:0]); end
            2: csrRead <= 1'b1;
            3: begin dataWrite <= 1'b1; dataIn <= v; end
            default: dataRead <= 1'b1;
        endcase
        @(posedge clk);
        {ctrlWrite, csrWrite, csrRead, dataWrite, dataRead} <= 5'h00;
    endtask
    task xfer(input logic [2:0] cfg, input logic [7:0] mo, input logic [7:0] mi,
              input logic [7:0] exr, input bit cl, input bit coll);
        acc(0, {2'h2, cfg, 1'b0, cfg[0], cfg[1]});
        acc(1, 8'h03);
        acc(0, {2'h3, cfg, 1'b1, cfg[0], cfg[1]});
        acc(2, 8'h00);
        chk("idle sck", {7'h0, sckOut}, {7'h0, cfg[0]});
        txByte <= mi;
        slvSelN <= 1'b0;
        acc(3, mo);
        prev = sckOut;
        t = 0;
        half = 0;
        last = 0;
        for (n = 0; n < 2000 && t < 16; n++)
        begin
            @(posedge clk);
            dataWrite <= coll && (t == 4);
            dataIn <= ~mo;
            #1;
            if (sckOut !== prev)
            begin
                t++;
                if (t == 2)
                    half = n - last;
                last = n;
                prev = sckOut;
            end
        end
        if (t < 16)
        begin
            mismatches++;
            end_of_test;
        end
        repeat (3) @(posedge clk);
        #1;
        slvSelN <= 1'b1;
        chk("half period", half[7:0], 8'(2 << ((cfg > 3'h5) ? 5 : cfg)));
        chk("slave got", slvRx, mo);
        chk("irq", {7'h0, irq}, {7'h0, ~cpuIntMask});
        if (cfg[2:1] != 2'h0)
            chk("rx byte", rxData, exr);
        if (coll)
            chk("collision", {7'h0, statusOut.writeCollisionFlag}, 8'h01);
        if (cl)
        begin
            acc(2, 8'h00);
            acc(4, 8'h00);
            @(posedge clk);
            #1;
            chk("status", {4'h0, statusOut}, 8'h00);
        end
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    //==============================================================
    // main sequence
    //==============================================================
    initial
    begin
        {nrst, ctrlWrite, csrWrite, csrRead, dataWrite, dataRead, cpuIntMask} = 7'h00;
        ctrlIn = CTRL_RESET;
        selIn = SEL_RESET;
        dataIn = 8'h00;
        txByte = 8'h00;
        {ssN, slvSelN, rxReady, tbSck, tbMosi} = 5'b11000;
        mismatches = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("ctrl reset", ctrlOut, 8'h00);
        chk("status reset", {4'h0, statusOut}, 8'h00);
        chk("sck oe reset", {7'h0, sckOe}, 8'h00);
        for (i = 0; i < 16; i++)
        begin
            cpuIntMask <= i[3];
            expq[i] = {i[2:1] != 2'h0, 8'hC0 + 8'(i)};
            xfer(i[2:0], 8'h5A ^ 8'(i), 8'hC0 + 8'(i), 8'hC0 + 8'(i), 1'b1, 1'b0);
        end
        chk("fifo full", {7'h0, rxValid}, 8'h01);
        txByte <= 8'hD0;
        slvSelN <= 1'b0;
        expq[16] = 9'h1D0;
        acc(3, 8'h77);
        repeat (40) @(posedge clk);
        chk("stalled done", {7'h0, statusOut.transferDoneFlag}, 8'h00);
        rxReady <= 1'b1;
        k = 0;
        for (n = 0; n < 3000 && k < 17; n++)
        begin
            @(negedge clk);
            if (rxValid === 1'b1)
            begin
                if (expq[k][8])
                    chk("stream", rxStream, expq[k][7:0]);
                k++;
            end
        end
        chk("drained", 8'(k), 8'd17);
        slvSelN <= 1'b1;
        acc(2, 8'h00);
        acc(4, 8'h00);
        cpuIntMask <= 1'b0;
        xfer(3'h2, 8'h11, 8'h22, 8'h22, 1'b0, 1'b0);
        acc(3, 8'h33);
        prev = sckOut;
        t = 0;
        repeat (30)
        begin
            @(posedge clk);
            #1;
            if (sckOut !== prev)
                t++;
        end
        chk("inhibited write", 8'(t), 8'h00);
        acc(2, 8'h00);
        xfer(3'h2, 8'h55, 8'h44, 8'h22, 1'b0, 1'b0);
        chk("overrun", {7'h0, statusOut.overrunFlag}, 8'h01);
        acc(2, 8'h00);
        #1;
        chk("overrun clear", {7'h0, statusOut.overrunFlag}, 8'h00);
        acc(4, 8'h00);
        xfer(3'h3, 8'h81, 8'h18, 8'h18, 1'b1, 1'b1);
        acc(1, 8'h02);
        repeat (2) @(posedge clk);
        #1;
        chk("fault drop", {6'h0, ctrlOut.portEnable, ctrlOut.masterSelect}, 8'h00);
        chk("fault flag", {4'h0, statusOut}, 8'h01);
        chk("fault irq", {6'h0, irq, sckOe}, 8'h02);
        acc(1, 8'h00);
        acc(2, 8'h00);
        acc(0, 8'hD4);
        @(posedge clk);
        #1;
        chk("restored", ctrlOut, 8'hD4);
        chk("fault cleared", {4'h0, statusOut}, 8'h00);
        ssN <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("pin fault", {6'h0, ctrlOut.portEnable, statusOut.masterFaultFlag}, 8'h01);
        // slave mode: bench plays the master on the pins, 16-cycle serial clock period
        ssN <= 1'b1;
        acc(2, 8'h00);
        acc(0, 8'hC0);
        acc(3, 8'hA5);
        ssN <= 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            tbMosi <= 1'(8'h3C >> i);
            repeat (8) @(posedge clk);
            chk("slave out", {7'h0, misoOut}, {7'h0, 1'(8'hA5 >> i)});
            tbSck <= 1'b1;
            repeat (8) @(posedge clk);
            tbSck <= 1'b0;
        end
        ssN <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("slave rx", rxData, 8'h3C);
        chk("slave done", {4'h0, statusOut}, 8'h08);
        acc(2, 8'h00);
        acc(3, 8'h00);
        @(posedge clk);
        #1;
        chk("slave clear", {4'h0, statusOut}, 8'h00);
        end_of_test;
    end
endmodule // tb_smsp_port
`default_nettype wire
